// ===== prw_mem_model.sv
// Program memory and normal data-target stand-in for the ROM window bench
`timescale 1ns/1ps
`default_nettype none
module prw_mem_model (
   // Program memory side
   input  wire logic [11:0] rom_addr_i,
   output logic      [7:0]  rom_data_o,
   // Normal data targets
   input  wire logic [7:0]  dbus_addr_i,
   output logic      [7:0]  other_rdata_o
);
   // Pattern differs per block so a wrong block number shows
   assign rom_data_o    = rom_addr_i[7:0] ^ {rom_addr_i[11:8], rom_addr_i[11:8]};
   assign other_rdata_o = ~dbus_addr_i;
endmodule
`default_nettype wire

// ===== prw_option_store.sv
// One-time-programmable option word, or a fixed mask value
`timescale 1ns/1ps
`default_nettype none
module prw_option_store #(
   parameter bit          MASKED     = 1'b0,
   parameter logic [15:0] MASK_VALUE = 16'h0010
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Programming port
   input  wire logic        prog_mode_i,
   input  wire logic        prog_we_i,
   input  wire logic [15:0] prog_data_i,
   // Option word
   output logic      [15:0] opt_o,
   output logic             opt_locked_o
);
   logic [15:0] otp_bits;
   logic        otp_done;

   // Storage is modelled as flops; reset stands for the as-delivered state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         otp_bits <= prw_pkg::OPT_BLANK;
      end else if (!MASKED && prog_mode_i && prog_we_i && !otp_done) begin
         otp_bits <= prog_data_i;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         otp_done <= 1'b0;
      end else if (prog_mode_i && prog_we_i) begin
         otp_done <= 1'b1;
      end
   end

   assign opt_o        = MASKED ? MASK_VALUE : otp_bits;
   assign opt_locked_o = MASKED | otp_done;

   a_write_once: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(otp_done) && !MASKED |-> $stable(otp_bits))
      else $error("option word changed after programming");
   a_no_user_write: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(prog_mode_i) |-> $stable(otp_bits))
      else $error("option word written outside programming mode");
endmodule
`default_nettype wire

// ===== prw_pkg.sv
// Package: addresses, field widths and option bit positions for the ROM window block
package prw_pkg;
   localparam logic [7:0]  SEL_ADDR        = 8'hC9;
   localparam logic [7:0]  WIN_LO          = 8'h40;
   localparam logic [7:0]  WIN_HI          = 8'h7F;
   localparam int          BLOCK_W         = 6;
   localparam int          OFFS_W          = 6;
   localparam int          PADDR_W         = 12;
   localparam logic [15:0] OPT_BLANK       = 16'h0000;
   localparam int          OPT_EXT_STOP    = 9;
   localparam int          OPT_LVD         = 8;
   localparam int          OPT_PROTECT     = 7;
   localparam int          OPT_OSC_RC      = 6;
   localparam int          OPT_NMI_PULL    = 3;
   localparam int          OPT_TIMER_PIN_PULLUP    = 2;
   localparam int          OPT_WDG_HW      = 1;
   localparam int          OPT_OSG         = 0;
endpackage

// ===== prw_rom_window.sv
// ROM window block select, window read path and option decode
`timescale 1ns/1ps
`default_nettype none
module prw_rom_window #(
   parameter int          PADDR_W    = prw_pkg::PADDR_W,
   parameter bit          MASKED     = 1'b0,
   parameter logic [15:0] MASK_VALUE = 16'h0010
) (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Core data-space bus
   input  wire logic [7:0]         dbus_addr_i,
   input  wire logic               dbus_wr_i,
   input  wire logic               dbus_rd_i,
   input  wire logic [7:0]         dbus_wdata_i,
   input  wire logic [7:0]         dbus_other_rdata_i,
   output logic      [7:0]         dbus_rdata_o,
   output logic                    dbus_other_sel_o,
   // Program memory read port
   output logic      [PADDR_W-1:0] rom_addr_o,
   output logic                    rom_rd_o,
   input  wire logic [7:0]         rom_data_i,
   // Programming mode
   input  wire logic               prog_mode_i,
   input  wire logic               prog_we_i,
   input  wire logic [15:0]        prog_data_i,
   output logic                    opt_locked_o,
   // Option fan-out and stop gating
   input  wire logic               nmi_pin_i,
   input  wire logic               watchdog_active_i,
   input  wire logic               stop_request_i,
   output logic                    stop_allowed_o,
   output logic                    external_stop_control_o,
   output logic                    low_voltage_detect_enable_o,
   output logic                    readout_protect_o,
   output logic                    osc_rc_select_o,
   output logic                    nmi_pin_pullup_o,
   output logic                    timer_pin_pullup_o,
   output logic                    watchdog_hardware_select_o,
   output logic                    oscillator_safeguard_enable_o
);
   // Refuse widths that the concatenated ROM address cannot serve
   if (PADDR_W != prw_pkg::BLOCK_W + prw_pkg::OFFS_W) begin
      $error("PADDR_W must equal block plus offset width");
   end
   // A mask value must keep the reserved option bits as a programmer would
   if (MASKED && (MASK_VALUE[15:10] != 6'h00 || MASK_VALUE[5:4] != 2'h1)) begin
      $error("MASK_VALUE breaks the reserved option bits");
   end

   logic [prw_pkg::BLOCK_W-1:0] rom_window_block_select;
   logic [15:0]                 opt;
   logic [2:0]                  nmi_sync;
   logic                        nmi_level;
   logic                        sel_loaded;

   function automatic logic in_window(input logic [7:0] a);
      in_window = (a >= prw_pkg::WIN_LO) && (a <= prw_pkg::WIN_HI);
   endfunction

   function automatic logic sel_write(input logic wr, input logic [7:0] a);
      sel_write = wr && (a == prw_pkg::SEL_ADDR);
   endfunction

   // No reset branch: contents undefined until the first write
   always_ff @(posedge clk_i) begin
      if (sel_write(dbus_wr_i, dbus_addr_i)) begin
         rom_window_block_select <= dbus_wdata_i[prw_pkg::BLOCK_W-1:0];
      end
   end

   // Only for checks: marks the end of the undefined start
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_loaded <= 1'b0;
      end else if (sel_write(dbus_wr_i, dbus_addr_i)) begin
         sel_loaded <= 1'b1;
      end
   end

   // Window read is combinational; ROM answers in the same core cycle
   assign rom_addr_o = {rom_window_block_select, dbus_addr_i[prw_pkg::OFFS_W-1:0]};
   assign rom_rd_o   = dbus_rd_i && in_window(dbus_addr_i);

   // Select is write-only: reads of it go nowhere, the bus sees the other target's value
   assign dbus_other_sel_o = !in_window(dbus_addr_i) && dbus_addr_i != prw_pkg::SEL_ADDR;
   assign dbus_rdata_o     = in_window(dbus_addr_i) ? rom_data_i
                           : dbus_other_rdata_i;

   prw_option_store #(
      .MASKED     (MASKED),
      .MASK_VALUE (MASK_VALUE)
   ) u_opt (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .prog_mode_i  (prog_mode_i),
      .prog_we_i    (prog_we_i),
      .prog_data_i  (prog_data_i),
      .opt_o        (opt),
      .opt_locked_o (opt_locked_o)
   );

   // NMI pin is asynchronous; second and third stages must agree
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         nmi_sync <= 3'h0;
      end else begin
         nmi_sync <= {nmi_sync[1:0], nmi_pin_i};
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         nmi_level <= 1'b0;
      end else if (nmi_sync[1] == nmi_sync[2]) begin
         nmi_level <= nmi_sync[2];
      end
   end

   assign external_stop_control_o       = opt[prw_pkg::OPT_EXT_STOP];
   assign low_voltage_detect_enable_o   = opt[prw_pkg::OPT_LVD];
   assign readout_protect_o             = opt[prw_pkg::OPT_PROTECT];
   assign osc_rc_select_o               = opt[prw_pkg::OPT_OSC_RC];
   assign nmi_pin_pullup_o              = opt[prw_pkg::OPT_NMI_PULL];
   assign timer_pin_pullup_o            = opt[prw_pkg::OPT_TIMER_PIN_PULLUP];
   assign watchdog_hardware_select_o    = opt[prw_pkg::OPT_WDG_HW];
   assign oscillator_safeguard_enable_o = opt[prw_pkg::OPT_OSG];

   // Hardware watchdog counts as active even if the watchdog unit says otherwise
   always_comb begin
      logic wdg_on;
      wdg_on = watchdog_active_i || opt[prw_pkg::OPT_WDG_HW];
      stop_allowed_o = stop_request_i &&
                       (!wdg_on || (opt[prw_pkg::OPT_EXT_STOP] && nmi_level));
   end

   // Select register and window address
   a_window_addr: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_write(dbus_wr_i, dbus_addr_i)
      |=> rom_addr_o[PADDR_W-1:prw_pkg::OFFS_W] == $past(dbus_wdata_i[prw_pkg::BLOCK_W-1:0]))
      else $error("window block differs from last select write");

   a_sel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_loaded && !sel_write(dbus_wr_i, dbus_addr_i)
      |=> rom_addr_o[PADDR_W-1:prw_pkg::OFFS_W] == $past(rom_addr_o[PADDR_W-1:prw_pkg::OFFS_W]))
      else $error("block changed without a select write");

   a_rom_offset: assert property (@(posedge clk_i) disable iff (rst_i)
      rom_addr_o[prw_pkg::OFFS_W-1:0] == dbus_addr_i[prw_pkg::OFFS_W-1:0])
      else $error("window offset not taken from the data address");

   // Window reads and the normal targets
   a_window_read: assert property (@(posedge clk_i) disable iff (rst_i)
      dbus_rd_i && in_window(dbus_addr_i)
      |-> rom_rd_o && dbus_rdata_o == rom_data_i)
      else $error("window read not served from program memory");

   a_rom_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      !dbus_rd_i |-> !rom_rd_o)
      else $error("program memory read without a bus read");

   a_other_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      !in_window(dbus_addr_i)
      |-> !rom_rd_o && dbus_rdata_o == dbus_other_rdata_i)
      else $error("non-window access disturbed");

   a_other_sel_win: assert property (@(posedge clk_i) disable iff (rst_i)
      in_window(dbus_addr_i) |-> !dbus_other_sel_o)
      else $error("window address passed to other target");

   a_other_sel_rest: assert property (@(posedge clk_i) disable iff (rst_i)
      !in_window(dbus_addr_i) && dbus_addr_i != prw_pkg::SEL_ADDR |-> dbus_other_sel_o)
      else $error("normal address not passed to other target");

   a_sel_decode: assert property (@(posedge clk_i) disable iff (rst_i)
      dbus_addr_i == prw_pkg::SEL_ADDR |-> !dbus_other_sel_o)
      else $error("select address passed to other target");

   a_sel_read: assert property (@(posedge clk_i) disable iff (rst_i)
      dbus_rd_i && dbus_addr_i == prw_pkg::SEL_ADDR
      |-> !rom_rd_o && dbus_rdata_o == dbus_other_rdata_i)
      else $error("select register read returned a value");

   // Stop gating; NMI filter takes about four cycles
   a_stop_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      watchdog_active_i && !external_stop_control_o |-> !stop_allowed_o)
      else $error("stop allowed with active watchdog");

   a_stop_nmi: assert property (@(posedge clk_i) disable iff (rst_i)
      stop_request_i && external_stop_control_o && nmi_pin_i [*6]
      |-> stop_allowed_o)
      else $error("stop refused with NMI high and option set");

   a_stop_nmi_low: assert property (@(posedge clk_i) disable iff (rst_i)
      watchdog_active_i && !nmi_level |-> !stop_allowed_o)
      else $error("stop allowed with watchdog on and NMI low");

   a_stop_free: assert property (@(posedge clk_i) disable iff (rst_i)
      stop_request_i && !watchdog_active_i && !watchdog_hardware_select_o
      |-> stop_allowed_o)
      else $error("stop refused with watchdog off");

   a_no_request: assert property (@(posedge clk_i) disable iff (rst_i)
      !stop_request_i |-> !stop_allowed_o)
      else $error("stop allowed without a request");

   a_hw_watchdog: assert property (@(posedge clk_i) disable iff (rst_i)
      watchdog_hardware_select_o && !external_stop_control_o |-> !stop_allowed_o)
      else $error("hardware watchdog did not block stop");

   a_nmi_settle: assert property (@(posedge clk_i) disable iff (rst_i)
      nmi_sync[1] != nmi_sync[2] |=> $stable(nmi_level))
      else $error("NMI level moved while stages disagree");

   a_nmi_follow: assert property (@(posedge clk_i) disable iff (rst_i)
      nmi_sync[1] == nmi_sync[2] |=> nmi_level == $past(nmi_sync[2]))
      else $error("NMI level missed an agreed change");

   // Option word and its fan-out
   a_opt_fanout: assert property (@(posedge clk_i) disable iff (rst_i)
      {low_voltage_detect_enable_o, readout_protect_o, osc_rc_select_o,
       oscillator_safeguard_enable_o} == {opt[8], opt[7], opt[6], opt[0]})
      else $error("option fan-out mismatch");

   a_lock_set: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i |=> opt_locked_o)
      else $error("option word not locked after programming");

   a_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      opt_locked_o |=> opt_locked_o)
      else $error("option lock released");

   a_opt_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
      opt_locked_o |=> $stable(opt))
      else $error("option word changed while locked");

   a_opt_refused: assert property (@(posedge clk_i) disable iff (rst_i)
      !(prog_mode_i && prog_we_i) |=> $stable(opt))
      else $error("option word changed without a programming write");

   // Each option output follows the first accepted programming word
   a_ext_stop_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i && !opt_locked_o
      |=> external_stop_control_o == $past(prog_data_i[prw_pkg::OPT_EXT_STOP]))
      else $error("external stop option not taken");

   a_lvd_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i && !opt_locked_o
      |=> low_voltage_detect_enable_o == $past(prog_data_i[prw_pkg::OPT_LVD]))
      else $error("low voltage option not taken");

   a_protect_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i && !opt_locked_o
      |=> readout_protect_o == $past(prog_data_i[prw_pkg::OPT_PROTECT]))
      else $error("readout protect option not taken");

   a_osc_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i && !opt_locked_o
      |=> osc_rc_select_o == $past(prog_data_i[prw_pkg::OPT_OSC_RC]))
      else $error("oscillator option not taken");

   a_nmi_pull_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i && !opt_locked_o
      |=> nmi_pin_pullup_o == $past(prog_data_i[prw_pkg::OPT_NMI_PULL]))
      else $error("NMI pull-up option not taken");

   a_timer_pin_pullup_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i && !opt_locked_o
      |=> timer_pin_pullup_o == $past(prog_data_i[prw_pkg::OPT_TIMER_PIN_PULLUP]))
      else $error("timer pull-up option not taken");

   a_wdg_hw_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i && !opt_locked_o
      |=> watchdog_hardware_select_o == $past(prog_data_i[prw_pkg::OPT_WDG_HW]))
      else $error("watchdog option not taken");

   a_osg_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      prog_mode_i && prog_we_i && !opt_locked_o
      |=> oscillator_safeguard_enable_o == $past(prog_data_i[prw_pkg::OPT_OSG]))
      else $error("safeguard option not taken");
endmodule
`default_nettype wire

// ===== prw_rom_window_test.sv
// Self-checking bench for the ROM window and option block
`timescale 1ns/1ps
`default_nettype none
module prw_rom_window_test;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  addr = 8'h00, wdata = 8'h00;
   logic        wr = 1'b0, rd = 1'b0, pmode = 1'b0, pwe = 1'b0;
   logic        nmi = 1'b0, wdg = 1'b0, sreq = 1'b0;
   logic [15:0] pdata = 16'h0000;
   logic [7:0]  sel_image = 8'h00;
   wire  [7:0]  other_rd, rdata, rom_data, opt;
   wire  [11:0] rom_addr;
   wire         other_sel, rom_rd, locked, stop_ok;
   int          err_count = 0;
   int          cmp_count = 0;

   always #12.5 clk_i = ~clk_i;

   prw_rom_window dut (.clk_i(clk_i), .rst_i(rst_i), .dbus_addr_i(addr), .dbus_wr_i(wr),
      .dbus_rd_i(rd), .dbus_wdata_i(wdata), .dbus_other_rdata_i(other_rd),
      .dbus_rdata_o(rdata), .dbus_other_sel_o(other_sel), .rom_addr_o(rom_addr),
      .rom_rd_o(rom_rd), .rom_data_i(rom_data), .prog_mode_i(pmode), .prog_we_i(pwe),
      .prog_data_i(pdata), .opt_locked_o(locked), .nmi_pin_i(nmi),
      .watchdog_active_i(wdg), .stop_request_i(sreq), .stop_allowed_o(stop_ok),
      .external_stop_control_o(opt[7]), .low_voltage_detect_enable_o(opt[6]),
      .readout_protect_o(opt[5]), .osc_rc_select_o(opt[4]), .nmi_pin_pullup_o(opt[3]),
      .timer_pin_pullup_o(opt[2]), .watchdog_hardware_select_o(opt[1]),
      .oscillator_safeguard_enable_o(opt[0]));

   prw_mem_model mem (.rom_addr_i(rom_addr), .rom_data_o(rom_data), .dbus_addr_i(addr),
      .other_rdata_o(other_rd));

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a; wdata <= d; wr <= 1'b1; rd <= 1'b0;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a);
      @(posedge clk_i);
      addr <= a; rd <= 1'b1;
      @(negedge clk_i);
   endtask

   task automatic win_case(input logic [7:0] sel, input logic [5:0] off);
      logic [11:0] ea;
      ea = {sel[5:0], off};
      sel_image = sel;
      bus_wr(prw_pkg::SEL_ADDR, sel);
      bus_rd({2'b01, off});
      chk("rom_addr block", {10'h0, rom_addr[11:6]}, {10'h0, sel_image[5:0]});
      chk("rom_addr", {4'h0, rom_addr}, {4'h0, ea});
      chk("rom_rd", {15'h0, rom_rd}, 16'h0001);
      chk("other_sel", {15'h0, other_sel}, 16'h0000);
      chk("rdata", {8'h0, rdata}, {8'h0, ea[7:0] ^ {ea[11:8], ea[11:8]}});
   endtask

   task automatic test_other();
      logic [7:0] al [4] = '{8'h3F, 8'h80, 8'hC9, 8'hFF};
      foreach (al[i]) begin
         bus_rd(al[i]);
         chk("rom_rd", {15'h0, rom_rd}, 16'h0000);
         chk("rdata", {8'h0, rdata}, {8'h0, ~al[i]});
         chk("other_sel", {15'h0, other_sel}, {15'h0, al[i] != 8'hC9});
      end
      bus_rd(8'h4A);
      chk("rom_addr", {4'h0, rom_addr}, 16'h000A);
      $display("test other addresses done");
   endtask

   task automatic prog(input logic pm, input logic [15:0] d);
      @(posedge clk_i);
      pmode <= pm; pwe <= 1'b1; pdata <= d;
      @(posedge clk_i);
      pwe <= 1'b0; pmode <= 1'b0;
      @(negedge clk_i);
   endtask

   task automatic stop_case(input logic w, input logic n, input logic exp);
      @(posedge clk_i);
      wdg <= w; nmi <= n; sreq <= 1'b1;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      chk("stop_ok", {15'h0, stop_ok}, {15'h0, exp});
   endtask

   task automatic test_options();
      chk("opt blank", {8'h0, opt}, 16'h0000);
      chk("locked", {15'h0, locked}, 16'h0000);
      stop_case(1'b1, 1'b1, 1'b0);
      prog(1'b0, 16'h035D);
      chk("opt outside prog", {8'h0, opt}, 16'h0000);
      prog(1'b1, 16'h035D);
      chk("opt", {8'h0, opt}, 16'h00DD);
      chk("locked", {15'h0, locked}, 16'h0001);
      prog(1'b1, 16'h0292);
      chk("opt relock", {8'h0, opt}, 16'h00DD);
      stop_case(1'b1, 1'b0, 1'b0);
      stop_case(1'b1, 1'b1, 1'b1);
      stop_case(1'b0, 1'b0, 1'b1);
      $display("test options done");
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      test_options();
      win_case(8'hC5, 6'h0A);
      win_case(8'hFF, 6'h3F);
      win_case(8'h00, 6'h00);
      $display("test window done");
      test_other();
      give_verdict();
   end

   // Cuts a hang short
   initial begin
      #1ms;
      err_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
